/* shared/idc_defines.svh */
`ifndef IDC_DEFINES_SVH
`define IDC_DEFINES_SVH

// Instruction word and field layout
`define IDC_WORD_W 14
`define IDC_FILE_W 7
`define IDC_FILE_MSB 6
`define IDC_DEST_BIT 7
`define IDC_BIT_LSB 7
`define IDC_BIT_MSB 9
`define IDC_PTR_BIT 2
`define IDC_MODE_LSB 0
`define IDC_MODE_MSB 1
`define IDC_LIT8_MSB 7
`define IDC_LIT11_MSB 10
`define IDC_LIT9_MSB 8

// Timing
`define IDC_OSC_PER_CYCLE 4
`define IDC_PHASE_LAST 2'h3

// Destination select
`define IDC_DEST_ACC 1'h0
`define IDC_DEST_FILE 1'h1

`endif

/* shared/idc_pkg.sv */
package idc_pkg;

  typedef enum logic [1:0] {
    IDC_CLS_BYTE,
    IDC_CLS_BIT,
    IDC_CLS_LITCTL
  } idc_class_t;

  typedef enum logic [4:0] {
    IDC_OP_NOP,
    IDC_OP_BYTE_ALU,
    IDC_OP_BIT_SETCLR,
    IDC_OP_SKIP_IF_BIT_CLEAR,
    IDC_OP_SKIP_IF_BIT_SET,
    IDC_OP_DECREMENT_SKIP_ZERO,
    IDC_OP_INCREMENT_SKIP_ZERO,
    IDC_OP_CALL_DIRECT,
    IDC_OP_CALL_VIA_ACCUMULATOR,
    IDC_OP_RETURN,
    IDC_OP_RETURN_WITH_LITERAL,
    IDC_OP_RETURN_FROM_INTERRUPT,
    IDC_OP_JUMP_ABSOLUTE,
    IDC_OP_BRANCH_RELATIVE,
    IDC_OP_BRANCH_VIA_ACCUMULATOR,
    IDC_OP_INDIRECT_MOVE,
    IDC_OP_LITERAL
  } idc_op_t;

  typedef enum logic [1:0] {
    IDC_PM_PRE_INC,
    IDC_PM_PRE_DEC,
    IDC_PM_POST_INC,
    IDC_PM_POST_DEC
  } idc_ptr_mode_t;

endpackage

/* shared/idc_field_if.sv */
`timescale 1ns/10ps
`default_nettype none

interface idc_field_if;
  logic [13:0] word;
  idc_pkg::idc_class_t op_class;
  idc_pkg::idc_op_t op;
  logic [6:0] file_addr;
  logic dest_file;
  logic [2:0] bit_sel;
  logic ptr_sel;
  idc_pkg::idc_ptr_mode_t ptr_mode;
  logic [10:0] literal;
  logic uses_file;
  logic is_skip;
  logic base_two_cycle;

  modport decoder (input word, output op_class, op, file_addr, dest_file, bit_sel, ptr_sel,
                   ptr_mode, literal, uses_file, is_skip, base_two_cycle);
  modport user (output word, input op_class, op, file_addr, dest_file, bit_sel, ptr_sel,
                ptr_mode, literal, uses_file, is_skip, base_two_cycle);
endinterface

`default_nettype wire

/* logic/idc_field_decode.sv */
`timescale 1ns/10ps
`default_nettype none
`include "idc_defines.svh"

module idc_field_decode
  import idc_pkg::*;
(
  // Word in, fields out
  idc_field_if.decoder fld
);

  logic [13:0] w;

  assign w = fld.word;
  assign fld.file_addr = w[`IDC_FILE_MSB:0];
  assign fld.dest_file = w[`IDC_DEST_BIT];
  assign fld.bit_sel = w[`IDC_BIT_MSB:`IDC_BIT_LSB];
  assign fld.ptr_sel = w[`IDC_PTR_BIT];
  assign fld.ptr_mode = idc_ptr_mode_t'(w[`IDC_MODE_MSB:`IDC_MODE_LSB]);
  assign fld.literal = w[`IDC_LIT11_MSB:0];

  // ****************************************************
  // Opcode classification
  // ****************************************************
  // Don't-care bits are never compared, only masked patterns
  always_comb begin
    fld.op_class = IDC_CLS_LITCTL;
    fld.op = IDC_OP_LITERAL;
    fld.uses_file = 1'b0;
    case (w[13:12])
      2'h0: begin
        fld.op_class = IDC_CLS_BYTE;
        fld.uses_file = 1'b1;
        fld.op = IDC_OP_BYTE_ALU;
        if (w[11:8] == 4'hB) begin
          fld.op = IDC_OP_DECREMENT_SKIP_ZERO;
        end else if (w[11:8] == 4'hF) begin
          fld.op = IDC_OP_INCREMENT_SKIP_ZERO;
        end else if (w[11:7] == 5'h00) begin
          // Control group with no file operand, except indirect moves
          fld.op_class = IDC_CLS_LITCTL;
          fld.uses_file = 1'b0;
          case (w[6:0])
            7'h08: fld.op = IDC_OP_RETURN;
            7'h09: fld.op = IDC_OP_RETURN_FROM_INTERRUPT;
            7'h0A: fld.op = IDC_OP_CALL_VIA_ACCUMULATOR;
            7'h0B: fld.op = IDC_OP_BRANCH_VIA_ACCUMULATOR;
            default: begin
              // Both move directions; bit 3 only picks the direction
              if (w[6:4] == 3'h1) begin
                fld.op = IDC_OP_INDIRECT_MOVE;
                fld.uses_file = 1'b1;
              end else begin
                fld.op = IDC_OP_NOP;
              end
            end
          endcase
        end
      end
      2'h1: begin
        fld.op_class = IDC_CLS_BIT;
        fld.uses_file = 1'b1;
        case (w[11:10])
          2'h2: fld.op = IDC_OP_SKIP_IF_BIT_CLEAR;
          2'h3: fld.op = IDC_OP_SKIP_IF_BIT_SET;
          default: fld.op = IDC_OP_BIT_SETCLR;
        endcase
      end
      2'h2: begin
        fld.op = w[11] ? IDC_OP_JUMP_ABSOLUTE : IDC_OP_CALL_DIRECT;
      end
      default: begin
        case (w[11:9])
          3'h1: fld.op = IDC_OP_BRANCH_RELATIVE;
          3'h2, 3'h3: fld.op = IDC_OP_RETURN_WITH_LITERAL;
          default: fld.op = IDC_OP_LITERAL;
        endcase
      end
    endcase
  end

  // ****************************************************
  // Cycle class
  // ****************************************************
  always_comb begin
    fld.is_skip = 1'b0;
    fld.base_two_cycle = 1'b0;
    case (fld.op)
      IDC_OP_CALL_DIRECT, IDC_OP_CALL_VIA_ACCUMULATOR: fld.base_two_cycle = 1'b1;
      IDC_OP_RETURN, IDC_OP_RETURN_WITH_LITERAL,
      IDC_OP_RETURN_FROM_INTERRUPT: fld.base_two_cycle = 1'b1;
      IDC_OP_JUMP_ABSOLUTE, IDC_OP_BRANCH_RELATIVE,
      IDC_OP_BRANCH_VIA_ACCUMULATOR: fld.base_two_cycle = 1'b1;
      IDC_OP_SKIP_IF_BIT_CLEAR, IDC_OP_SKIP_IF_BIT_SET,
      IDC_OP_DECREMENT_SKIP_ZERO, IDC_OP_INCREMENT_SKIP_ZERO: fld.is_skip = 1'b1;
      default: fld.base_two_cycle = 1'b0;
    endcase
  end

endmodule // idc_field_decode

`default_nettype wire

/* logic/idc_insn_decode.sv */
`timescale 1ns/10ps
`default_nettype none
`include "idc_defines.svh"

// What this block does
// - Takes one 14-bit word holding opcode and all operands.
// - Sorts opcodes into byte, bit, and literal-control classes.
// - Ordinary instructions finish in one instruction cycle.
// - Both call forms take two instruction cycles.
// - All three return forms take two instruction cycles.
// - Jumps and branches take two instruction cycles; skips take two only when the skip is taken.
// - Indirect access through pointer into program memory adds one cycle.
// - One instruction cycle is four oscillator clocks.
// - File operand is always read; it is written back only for bit set/clear and byte ops with destination 1.
// - Destination bit 0 selects accumulator, 1 the file register.
// - File field addresses 0x00 through 0x7F.
// - Bit field selects one of eight bit positions.
// - Pointer field selects pointer pair 0 or 1.
// - Don't-care word bits never change behaviour.
// - Two-bit mode picks pre/post increment/decrement of pointer.
// - Literal field carries immediate data or target address.
module idc_insn_decode
  import idc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Program memory side
  input wire logic [13:0] insn_word,
  input wire logic insn_valid,
  output logic insn_fetch,
  // Execution status from the data path
  input wire logic skip_taken,
  input wire logic ptr_in_program,
  // Decoded fields
  output idc_class_t op_class,
  output idc_op_t op,
  output logic [6:0] file_addr,
  output logic [2:0] bit_sel,
  output logic ptr_sel,
  output idc_ptr_mode_t ptr_mode,
  output logic [10:0] literal,
  // Data file side
  output logic file_read,
  output logic file_write,
  output logic acc_write,
  // Cycle timing
  output logic [1:0] osc_phase,
  output logic cycle_strobe,
  output logic [1:0] cycle_index,
  output logic busy
);

  // ****************************************************
  // Field decode
  // ****************************************************
  idc_field_if fld ();

  logic [13:0] cur_word;
  logic cur_valid;
  logic [1:0] phase;
  logic [1:0] idx;
  logic [1:0] cycles_left;
  logic phase_end;
  logic extra_cycle;
  logic [1:0] next_total;

  assign fld.word = cur_word;

  idc_field_decode u_field (
    .fld(fld)
  );

  // ****************************************************
  // Oscillator phase
  // ****************************************************
  assign phase_end = (phase == `IDC_PHASE_LAST);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // ****************************************************
  // Instruction latch
  // ****************************************************
  // A new word is taken only on the last phase of the final cycle
  logic take_word;
  logic [1:0] remaining;
  assign take_word = phase_end && (remaining == 2'h0);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cur_word <= 14'h0000;
      cur_valid <= 1'b0;
    end else if (take_word) begin
      cur_word <= insn_word;
      cur_valid <= insn_valid;
    end
  end

  // ****************************************************
  // Cycle count
  // ****************************************************
  // Extra cycle only for indirect moves with pointer into program memory
  assign extra_cycle = (fld.op == IDC_OP_INDIRECT_MOVE) && ptr_in_program;

  // In cycle 0 the count comes straight from the word being executed
  assign remaining = (idx == 2'h0) ? next_total : cycles_left;

  // Cycles remaining after the first, evaluated at end of cycle 0
  always_comb begin
    next_total = 2'h0;
    if (cur_valid) begin
      if (fld.base_two_cycle) begin
        next_total = 2'h1;
      end else if (fld.is_skip && skip_taken) begin
        next_total = 2'h1;
      end
      if (extra_cycle) begin
        next_total = next_total + 2'h1;
      end
    end else begin
      next_total = 2'h0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      idx <= 2'h0;
      cycles_left <= 2'h0;
    end else if (phase_end) begin
      if (take_word) begin
        idx <= 2'h0;
        cycles_left <= 2'h0;
      end else begin
        idx <= idx + 2'h1;
        cycles_left <= remaining - 2'h1;
      end
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  // Registered copies so every port comes straight from a flop
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      op_class <= IDC_CLS_LITCTL;
      op <= IDC_OP_NOP;
      file_addr <= 7'h00;
      bit_sel <= 3'h0;
      ptr_sel <= 1'b0;
      ptr_mode <= IDC_PM_PRE_INC;
      literal <= 11'h000;
    end else begin
      op_class <= fld.op_class;
      op <= cur_valid ? fld.op : IDC_OP_NOP;
      file_addr <= fld.file_addr;
      bit_sel <= fld.bit_sel;
      ptr_sel <= fld.ptr_sel;
      ptr_mode <= fld.ptr_mode;
      literal <= fld.literal;
    end
  end

  // Bit tests only read; bit set/clear always writes; byte ops follow d
  logic write_back;
  always_comb begin
    case (fld.op)
      IDC_OP_BIT_SETCLR: write_back = 1'b1;
      IDC_OP_SKIP_IF_BIT_CLEAR, IDC_OP_SKIP_IF_BIT_SET: write_back = 1'b0;
      default: write_back = (fld.op_class == IDC_CLS_BYTE) && (fld.dest_file == `IDC_DEST_FILE);
    endcase
  end

  // Read-modify-write: read in phase 0, write in phase 2 of cycle 0
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      file_read <= 1'b0;
      file_write <= 1'b0;
      acc_write <= 1'b0;
    end else begin
      file_read <= cur_valid && fld.uses_file && (idx == 2'h0) && (phase == 2'h0);
      file_write <= cur_valid && fld.uses_file && (idx == 2'h0) && (phase == 2'h2)
                    && write_back;
      acc_write <= cur_valid && (fld.op_class == IDC_CLS_BYTE) && (idx == 2'h0) && (phase == 2'h2)
                   && (fld.dest_file == `IDC_DEST_ACC);
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      osc_phase <= 2'h0;
      cycle_strobe <= 1'b0;
      cycle_index <= 2'h0;
      insn_fetch <= 1'b0;
      busy <= 1'b0;
    end else begin
      osc_phase <= phase;
      cycle_strobe <= phase_end;
      cycle_index <= idx;
      insn_fetch <= take_word;
      // Data path status is only settled one clock into cycle 0
      busy <= (idx != 2'h0) ? (cycles_left != 2'h0) : ((phase != 2'h0) && (next_total != 2'h0));
    end
  end

endmodule // idc_insn_decode

`default_nettype wire

/* dv/idc_insn_decode_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module idc_insn_decode_checker
  import idc_pkg::*;
(
  // Timing
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [1:0] osc_phase,
  input wire logic cycle_strobe,
  // Decode and file access
  input wire logic insn_fetch,
  input wire idc_op_t op,
  input wire logic file_read,
  input wire logic file_write
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic [3:0] gap;
  logic seen;
  // First fetch after reset has nothing to measure from
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      gap <= 4'h0;
      seen <= 1'b0;
    end else begin
      gap <= insn_fetch ? 4'h0 : gap + 4'h1;
      seen <= seen | insn_fetch;
    end
  end
  // ********
  // Assertions
  // ********
  a_cycle_len: assert property (cycle_strobe |=> !cycle_strobe [*3] ##1 cycle_strobe)
    else $error("cycle length wrong");
  a_phase_wrap: assert property (osc_phase == 2'h3 |=> osc_phase == 2'h0)
    else $error("phase wrap wrong");
  a_single_cycle: assert property (insn_fetch && seen && op inside {IDC_OP_NOP, IDC_OP_BYTE_ALU,
    IDC_OP_BIT_SETCLR, IDC_OP_LITERAL} |-> gap == 4'h3) else $error("single op length wrong");
  a_call_two: assert property (insn_fetch && seen && op inside {IDC_OP_CALL_DIRECT,
    IDC_OP_CALL_VIA_ACCUMULATOR} |-> gap == 4'h7) else $error("call length wrong");
  a_return_two: assert property (insn_fetch && seen && op inside {IDC_OP_RETURN,
    IDC_OP_RETURN_WITH_LITERAL, IDC_OP_RETURN_FROM_INTERRUPT} |-> gap == 4'h7) else $error("return length wrong");
  a_flow_two: assert property (insn_fetch && seen && op inside {IDC_OP_JUMP_ABSOLUTE,
    IDC_OP_BRANCH_RELATIVE, IDC_OP_BRANCH_VIA_ACCUMULATOR} |-> gap == 4'h7) else $error("branch length wrong");
  a_skip_cost: assert property (insn_fetch && seen && op inside {[IDC_OP_SKIP_IF_BIT_CLEAR:
    IDC_OP_INCREMENT_SKIP_ZERO]} |-> gap inside {4'h3, 4'h7}) else $error("skip length wrong");
  a_read_first: assert property (file_write |-> $past(file_read, 2)) else $error("write without read");
  c_call: cover property (insn_fetch && seen && op == IDC_OP_CALL_DIRECT);
  c_skip: cover property (insn_fetch && seen && gap == 4'h7 && op == IDC_OP_SKIP_IF_BIT_SET);
  c_write: cover property (file_write);
endmodule // idc_insn_decode_checker
bind idc_insn_decode idc_insn_decode_checker idc_insn_decode_checker_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .osc_phase(osc_phase), .cycle_strobe(cycle_strobe), .insn_fetch(insn_fetch), .op(op), .file_read(file_read),
  .file_write(file_write));
`default_nettype wire

/* dv/idc_prog_model.sv */
`timescale 1ns/10ps
`default_nettype none
module idc_prog_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Fetch side
  input wire logic insn_fetch,
  output logic [13:0] insn_word,
  output logic insn_valid,
  // Data path status
  output logic skip_taken,
  output logic ptr_in_program
);
  // Entry: valid, pointer in program, skip, word
  logic [16:0] mem [64];
  logic [5:0] idx;
  logic [16:0] cur;
  assign insn_word = mem[idx][13:0];
  assign insn_valid = mem[idx][16];
  // Status belongs to the word now executing, held until the next fetch
  assign skip_taken = cur[14];
  assign ptr_in_program = cur[15];
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      idx <= 6'h00;
      cur <= 17'h00000;
    end else if (insn_fetch) begin
      idx <= idx + 6'h01;
      cur <= mem[idx];
    end
  end
endmodule // idc_prog_model
`default_nettype wire

/* dv/test_insn_decode_cycle_timing.sv */
`timescale 1ns/10ps
`default_nettype none
module test_insn_decode_cycle_timing
  import idc_pkg::*;
;
  logic clk_sys, sys_rst, insn_valid, insn_fetch, skip_taken, ptr_in_program, ptr_sel, busy;
  logic file_read, file_write, acc_write, cycle_strobe;
  logic [13:0] insn_word;
  logic [10:0] literal;
  logic [6:0] file_addr;
  logic [2:0] bit_sel;
  logic [1:0] osc_phase, cycle_index;
  idc_class_t op_class;
  idc_op_t op;
  idc_ptr_mode_t ptr_mode;
  int err_count = 0;
  int num_checks = 0;
  // Opcode families: base word and random operand bits
  logic [13:0] fam [18] = '{14'h0200, 14'h0700, 14'h0080, 14'h1000, 14'h1800, 14'h1C00, 14'h0B00, 14'h0F00,
    14'h2000, 14'h2800, 14'h3400, 14'h3200, 14'h3000, 14'h0008, 14'h0009, 14'h000A, 14'h000B, 14'h0010};
  logic [13:0] msk [18] = '{14'h00FF, 14'h00FF, 14'h007F, 14'h07FF, 14'h03FF, 14'h03FF, 14'h00FF, 14'h00FF,
    14'h07FF, 14'h07FF, 14'h03FF, 14'h01FF, 14'h00FF, 14'h0000, 14'h0000, 14'h0000, 14'h0000, 14'h000F};
  idc_prog_model idc_prog_model_i (.*);
  idc_insn_decode idc_insn_decode_i (.*);
  // ********
  // Expectations
  // ********
  function automatic idc_op_t exp_op(logic [13:0] w);
    casez (w)
      14'h0008: return IDC_OP_RETURN;
      14'h0009: return IDC_OP_RETURN_FROM_INTERRUPT;
      14'h000A: return IDC_OP_CALL_VIA_ACCUMULATOR;
      14'h000B: return IDC_OP_BRANCH_VIA_ACCUMULATOR;
      14'h001?: return IDC_OP_INDIRECT_MOVE;
      14'h0B??: return IDC_OP_DECREMENT_SKIP_ZERO;
      14'h0F??: return IDC_OP_INCREMENT_SKIP_ZERO;
      14'h0???: return IDC_OP_BYTE_ALU;
      14'b010???????????: return IDC_OP_BIT_SETCLR;
      14'b0110??????????: return IDC_OP_SKIP_IF_BIT_CLEAR;
      14'b0111??????????: return IDC_OP_SKIP_IF_BIT_SET;
      14'b100???????????: return IDC_OP_CALL_DIRECT;
      14'b101???????????: return IDC_OP_JUMP_ABSOLUTE;
      14'b11001?????????: return IDC_OP_BRANCH_RELATIVE;
      14'b1101??????????: return IDC_OP_RETURN_WITH_LITERAL;
      default: return IDC_OP_LITERAL;
    endcase
  endfunction
  function automatic int exp_cyc(logic [16:0] e);
    idc_op_t o;
    o = e[16] ? exp_op(e[13:0]) : IDC_OP_NOP;
    if (o inside {[IDC_OP_SKIP_IF_BIT_CLEAR:IDC_OP_INCREMENT_SKIP_ZERO]}) return 1 + e[14];
    if (o == IDC_OP_INDIRECT_MOVE) return 1 + e[15];
    if (o inside {[IDC_OP_CALL_DIRECT:IDC_OP_BRANCH_VIA_ACCUMULATOR]}) return 2;
    return 1;
  endfunction
  task automatic check_val(logic [15:0] got, logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_cnt(int got, int exp);
    num_checks++;
    if (got != exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic load_prog(bit rnd);
    int f;
    for (int i = 0; i < 64; i++) begin
      f = rnd ? $urandom_range(17) : i % 18;
      idc_prog_model_i.mem[i] = {rnd ? ($urandom_range(7) != 0) : 1'b1, 2'($urandom), fam[f] | (msk[f] & 14'($urandom))};
    end
  endtask
  // Gap between fetches and file strobes are tallied per word
  task automatic run_prog(int n);
    logic [16:0] e;
    int gap, rd, wr, aw;
    for (int i = 0; i < 20 && insn_fetch !== 1'b1; i++) @(negedge clk_sys);
    for (int k = 0; k < n; k++) begin
      e = idc_prog_model_i.mem[k];
      gap = 0;
      rd = 0;
      wr = 0;
      aw = 0;
      do begin
        @(negedge clk_sys);
        gap++;
        rd += (file_read === 1'b1);
        wr += (file_write === 1'b1);
        aw += (acc_write === 1'b1);
        if (gap == 3) begin
          check_val(16'(op), 16'(e[16] ? exp_op(e[13:0]) : IDC_OP_NOP));
          check_val(16'(busy), 16'(exp_cyc(e) > 1));
          if (e[16] && e[13:0] > 14'h001F) check_val(16'(op_class), 16'(e[13] ? IDC_CLS_LITCTL : e[12] ? IDC_CLS_BIT : IDC_CLS_BYTE));
          if (e[16]) begin
            check_val(16'(file_addr), 16'(e[6:0]));
            check_val(16'(bit_sel), 16'(e[9:7]));
            check_val(16'(ptr_sel), 16'(e[2]));
            check_val(16'(ptr_mode), 16'(e[1:0]));
            check_val(16'(literal), 16'(e[10:0]));
          end
        end
        if (gap % 4 == 3) check_val(16'(cycle_index), 16'(gap / 4));
      end while (insn_fetch !== 1'b1 && gap < 16);
      check_cnt(gap, 4 * exp_cyc(e));
      if (e[16] && exp_op(e[13:0]) == IDC_OP_BYTE_ALU) begin
        check_cnt(rd, 1);
        check_cnt(wr, e[7]);
        check_cnt(aw, !e[7]);
      end
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Two runs of 60 words at 8 clocks at most, with margin
  initial begin
    repeat (4000) @(posedge clk_sys);
    err_count++;
    complete_run();
  end
  // Second reset lands while the decoder is mid-program
  initial begin
    sys_rst = 1'b1;
    void'($urandom(13));
    for (int t = 0; t < 2; t++) begin
      @(posedge clk_sys);
      sys_rst <= 1'b1;
      load_prog(t[0]);
      repeat (4) @(posedge clk_sys);
      sys_rst <= 1'b0;
      run_prog(60);
      $display("test %0d done", t);
    end
    complete_run();
  end
endmodule // test_insn_decode_cycle_timing
`default_nettype wire
